// [logic/mpoc_pkg.sv]
/*
 * Constants of the motor PWM output control block: register offsets, field positions,
 * reset values and the dead-time prescale encoding.
 * Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
 */
package mpoc_pkg;

	// Register byte offsets
	localparam logic [7:0] MPOC_OFS_PAIR_PIN   = 8'h00;
	localparam logic [7:0] MPOC_OFS_UPDATE     = 8'h04;
	localparam logic [7:0] MPOC_OFS_DT_VALUES  = 8'h08;
	localparam logic [7:0] MPOC_OFS_DT_SELECT  = 8'h0C;
	localparam logic [7:0] MPOC_OFS_FAULT      = 8'h10;
	localparam logic [7:0] MPOC_OFS_STATUS     = 8'h14;

	// Pair mode and pin enable fields
	localparam int MPOC_POS_PAIR_MODE = 8;
	localparam int MPOC_POS_HIGH_EN   = 4;
	localparam int MPOC_POS_LOW_EN    = 0;

	// Update and trigger control fields
	localparam int MPOC_POS_POSTSCALE = 8;
	localparam int MPOC_POS_IMMEDIATE = 2;
	localparam int MPOC_POS_OVR_SYNC  = 1;
	localparam int MPOC_POS_INHIBIT   = 0;

	// Dead-time value fields
	localparam int MPOC_POS_DTB_PS    = 14;
	localparam int MPOC_POS_DTB_COUNT = 8;
	localparam int MPOC_POS_DTA_PS    = 6;
	localparam int MPOC_POS_DTA_COUNT = 0;

	// Fault A control fields
	localparam int MPOC_POS_FAULT_OVR  = 8;
	localparam int MPOC_POS_FAULT_MODE = 7;
	localparam int MPOC_POS_FAULT_EN   = 0;

	// Status fields; writing one to the held bit clears a latched fault
	localparam int MPOC_POS_ST_FAULT_IN   = 0;
	localparam int MPOC_POS_ST_FAULT_HELD = 1;
	localparam int MPOC_POS_ST_DUTY_PEND  = 2;
	localparam int MPOC_POS_ST_STRAP      = 3;

	// Reset values
	localparam logic [2:0]  MPOC_RST_PAIR_MODE = 3'h0;
	localparam logic [15:0] MPOC_RST_UPDATE    = 16'h0000;
	localparam logic [15:0] MPOC_RST_DT_VALUES = 16'h0000;
	localparam logic [15:0] MPOC_RST_DT_SELECT = 16'h0000;
	localparam logic [15:0] MPOC_RST_FAULT     = 16'h0000;
	localparam logic [5:0]  MPOC_RST_OVR_CTL   = 6'h3F;
	localparam logic [5:0]  MPOC_RST_OVR_VAL   = 6'h00;

	// Number of enabled clock edges before the synchronised strap is trusted
	localparam logic [1:0] MPOC_STRAP_SETTLE = 2'h2;

	localparam int MPOC_DT_LEN_W = 9;

	// Dead time in cycles: count times 1, 2, 4 or 8 Tcy
	function automatic logic [MPOC_DT_LEN_W-1:0] mpoc_dt_len(input logic [5:0] count,
	                                                         input logic [1:0] ps);
		mpoc_dt_len = {3'h0, count} << ps;
	endfunction

endpackage

// [logic/mpoc_deadtime.sv]
/*
 * Dead-time generator for one complementary output pair.
 * Assumes raw_in comes from PWM logic on hclk; lengths are counted in enabled hclk cycles.
 */
`timescale 1ns/100ps
module mpoc_deadtime
	import mpoc_pkg::*;
(
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     clk_en,
	input  wire logic                     raw_in,
	input  wire logic [MPOC_DT_LEN_W-1:0] rise_len,
	input  wire logic [MPOC_DT_LEN_W-1:0] fall_len,
	output logic                          high_out,
	output logic                          low_out
);

	typedef enum logic [1:0] {DT_OFF, DT_WAIT_HIGH, DT_HIGH, DT_WAIT_LOW} mpoc_dt_state_t;

	mpoc_dt_state_t           state_reg;
	mpoc_dt_state_t           state_next;
	logic [MPOC_DT_LEN_W-1:0] cnt_reg;
	logic [MPOC_DT_LEN_W-1:0] cnt_next;

	// Low falls at once on a raw rise, high waits; mirror image on a raw fall
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			DT_OFF, DT_WAIT_LOW: begin
				if (raw_in) begin
					cnt_next   = rise_len;
					state_next = (rise_len == '0) ? DT_HIGH : DT_WAIT_HIGH; // see (RULE_22)
				end else if (cnt_reg > 1) begin
					cnt_next = cnt_reg - 1'b1;
				end else begin
					cnt_next = '0;
				end
			end
			DT_WAIT_HIGH: begin
				if (!raw_in) begin
					cnt_next   = fall_len;
					state_next = (fall_len == '0) ? DT_WAIT_LOW : DT_OFF;
				end else if (cnt_reg <= 1) begin
					state_next = DT_HIGH;
				end else begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			DT_HIGH: begin
				if (!raw_in) begin
					cnt_next   = fall_len;
					state_next = (fall_len == '0) ? DT_WAIT_LOW : DT_OFF; // see (RULE_22)
				end
			end
			default: state_next = DT_OFF;
		endcase
	end

	// DT_OFF holds both off while the fall delay runs; DT_WAIT_LOW with count 0 drives low
	logic low_next;
	always_comb begin
		low_next = (state_next == DT_WAIT_LOW) && (cnt_next == '0);
		if (state_next == DT_OFF && cnt_next <= 1 && state_reg == DT_OFF && !raw_in)
			low_next = 1'b0;
	end

	logic wait_done;
	assign wait_done = (state_reg == DT_OFF) && !raw_in && (cnt_reg <= 1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= DT_OFF;
			cnt_reg   <= '0;
			high_out  <= 1'b0;
			low_out   <= 1'b0;
		end else if (clk_en) begin
			state_reg <= wait_done ? DT_WAIT_LOW : state_next;
			cnt_reg   <= wait_done ? '0 : cnt_next;
			high_out  <= (state_next == DT_HIGH);
			low_out   <= wait_done || low_next; // see (RULE_02)
		end
	end

endmodule // mpoc_deadtime

// [logic/mpoc_top.sv]
/*
 * Motor PWM output control: pair modes, pin hand-over, trigger postscaler, duty and
 * override update timing, two dead-time units and Fault A override, behind AHB-Lite.
 * Assumes raw PWM, time-base sync and event match come from logic on hclk; the fault
 * input and the power-on strap are asynchronous pins.
 */
// Behaviour
// (RULE_01) Pair mode bit one gives independent outputs, zero gives complementary outputs.
// (RULE_02) In complementary mode low output is inverse of high, except dead time.
// (RULE_03) High pin enable one routes PWM to pin; zero releases it to GPIO.
// (RULE_04) Low pin enable one routes PWM to pin; zero releases it to GPIO.
// (RULE_05) Pin enable reset value comes from the power-on configuration strap.
// (RULE_06) Special event trigger postscaled: field n gives one trigger per n+1 matches.
// (RULE_07) Immediate bit applies duty writes at once, else at time base sync.
// (RULE_08) Override sync bit applies manual overrides at time base sync, else next cycle.
// (RULE_09) Update inhibit bit blocks duty and period buffer transfers.
// (RULE_10) Dead-time unit B clock period is 1, 2, 4 or 8 Tcy.
// (RULE_11) Dead-time unit A clock period is 1, 2, 4 or 8 Tcy.
// (RULE_12) Dead-time unit B holds a six-bit unsigned dead-time count.
// (RULE_13) Dead-time unit A holds a six-bit unsigned dead-time count.
// (RULE_14) Per pair, high going active uses unit B when bit set, else A.
// (RULE_15) Per pair, low going active edge uses unit B when bit set, else A.
// (RULE_16) Fault forces each controlled pin to its own override level bit.
// (RULE_17) Cycle mode releases fault override after the fault input deasserts.
// (RULE_18) Latched mode holds fault override until software clears it.
// (RULE_19) Per pair fault enable places that pair under Fault A control.
// (RULE_20) Two-channel instance implements only the first pair.
// (RULE_21) Unimplemented bits ignore writes and read as zero.
// (RULE_22) Dead time equals count times prescaled period, delaying the going-active edge.
`timescale 1ns/100ps
module mpoc_top
	import mpoc_pkg::*;
#(
	parameter int PAIR_COUNT = 3
)(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        pin_owner_config_bit,
	input  wire logic        fault_a_pin_n,
	input  wire logic [2:0]  pwm_raw_high,
	input  wire logic [2:0]  pwm_raw_low,
	input  wire logic        time_base_sync,
	input  wire logic        special_event_match,
	input  wire logic        duty_buffer_write,
	input  wire logic [5:0]  override_pwm_control,
	input  wire logic [5:0]  override_manual_value,
	output logic [2:0]       high_side_output,
	output logic [2:0]       low_side_output,
	output logic [2:0]       high_side_drive_en,
	output logic [2:0]       low_side_drive_en,
	output logic             special_event_trigger,
	output logic             duty_transfer,
	output logic             period_transfer
);

	// Pairs beyond PAIR_COUNT have no storage and read as zero
	localparam logic [2:0] PAIR_MASK = 3'((1 << PAIR_COUNT) - 1); // see (RULE_20)

	function automatic logic [5:0] pin_mask(input logic [2:0] pairs);
		pin_mask = {{2{pairs[2]}}, {2{pairs[1]}}, {2{pairs[0]}}};
	endfunction

	localparam logic [5:0] PIN_MASK = pin_mask(PAIR_MASK);

	// Register state
	logic [2:0] pair_independent_select_reg;
	logic [2:0] high_pin_enable_reg;
	logic [2:0] low_pin_enable_reg;
	logic [3:0] trigger_postscale_reg;
	logic       immediate_duty_update_reg;
	logic       override_sync_select_reg;
	logic       buffer_transfer_inhibit_reg;
	logic [1:0] deadtime_b_prescale_reg;
	logic [5:0] deadtime_b_count_reg;
	logic [1:0] deadtime_a_prescale_reg;
	logic [5:0] deadtime_a_count_reg;
	logic [5:0] edge_source_reg;
	logic [5:0] fault_override_level_reg;
	logic       fault_cycle_mode_reg;
	logic [2:0] fault_enable_reg;

	// Bus phase state
	logic       wr_pend_reg;
	logic       rd_pend_reg;
	logic [7:0] dp_addr_reg;
	logic       addr_phase;
	logic       wr_strobe;

	assign addr_phase = hsel && htrans[1] && hready && clk_en && (hsize == 3'h2);
	assign wr_strobe  = wr_pend_reg && clk_en;
	assign hreadyout  = clk_en;
	assign hresp      = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
		end else if (clk_en) begin
			wr_pend_reg <= addr_phase && hwrite;
			rd_pend_reg <= addr_phase && !hwrite;
			if (addr_phase)
				dp_addr_reg <= {haddr[7:2], 2'h0};
		end
	end

	function automatic logic wr_hit(input logic [7:0] ofs, input logic [7:0] a,
	                               input logic stb);
		wr_hit = stb && (a == ofs);
	endfunction

	// Strap capture: two flip-flops, then loaded once after reset release
	logic       strap_sync1_reg;
	logic       strap_sync2_reg;
	logic [1:0] strap_settle_reg;
	logic       strap_load;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_sync1_reg  <= 1'b0;
			strap_sync2_reg  <= 1'b0;
			strap_settle_reg <= 2'h0;
		end else if (clk_en) begin
			strap_sync1_reg <= pin_owner_config_bit;
			strap_sync2_reg <= strap_sync1_reg;
			if (strap_settle_reg != 2'h3)
				strap_settle_reg <= strap_settle_reg + 2'h1;
		end
	end

	assign strap_load = (strap_settle_reg == MPOC_STRAP_SETTLE);

	// Pair mode and pin enables
	logic wr_pair_pin;
	assign wr_pair_pin = wr_hit(MPOC_OFS_PAIR_PIN, dp_addr_reg, wr_strobe);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pair_independent_select_reg <= MPOC_RST_PAIR_MODE;
			high_pin_enable_reg         <= 3'h0;
			low_pin_enable_reg          <= 3'h0;
		end else if (clk_en) begin
			if (strap_load) begin
				high_pin_enable_reg <= {3{strap_sync2_reg}} & PAIR_MASK; // see (RULE_05)
				low_pin_enable_reg  <= {3{strap_sync2_reg}} & PAIR_MASK; // see (RULE_05)
			end else if (wr_pair_pin) begin
				high_pin_enable_reg <= hwdata[MPOC_POS_HIGH_EN +: 3] & PAIR_MASK;
				low_pin_enable_reg  <= hwdata[MPOC_POS_LOW_EN +: 3] & PAIR_MASK;
			end
			if (wr_pair_pin)
				pair_independent_select_reg <= hwdata[MPOC_POS_PAIR_MODE +: 3] & PAIR_MASK;
		end
	end

	// Update/trigger, dead-time and fault configuration
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trigger_postscale_reg       <= MPOC_RST_UPDATE[MPOC_POS_POSTSCALE +: 4];
			immediate_duty_update_reg   <= MPOC_RST_UPDATE[MPOC_POS_IMMEDIATE];
			override_sync_select_reg    <= MPOC_RST_UPDATE[MPOC_POS_OVR_SYNC];
			buffer_transfer_inhibit_reg <= MPOC_RST_UPDATE[MPOC_POS_INHIBIT];
			deadtime_b_prescale_reg     <= MPOC_RST_DT_VALUES[MPOC_POS_DTB_PS +: 2];
			deadtime_b_count_reg        <= MPOC_RST_DT_VALUES[MPOC_POS_DTB_COUNT +: 6];
			deadtime_a_prescale_reg     <= MPOC_RST_DT_VALUES[MPOC_POS_DTA_PS +: 2];
			deadtime_a_count_reg        <= MPOC_RST_DT_VALUES[MPOC_POS_DTA_COUNT +: 6];
			edge_source_reg             <= MPOC_RST_DT_SELECT[5:0];
			fault_override_level_reg    <= MPOC_RST_FAULT[MPOC_POS_FAULT_OVR +: 6];
			fault_cycle_mode_reg        <= MPOC_RST_FAULT[MPOC_POS_FAULT_MODE];
			fault_enable_reg            <= MPOC_RST_FAULT[MPOC_POS_FAULT_EN +: 3];
		end else if (clk_en) begin
			if (wr_hit(MPOC_OFS_UPDATE, dp_addr_reg, wr_strobe)) begin
				trigger_postscale_reg       <= hwdata[MPOC_POS_POSTSCALE +: 4];
				immediate_duty_update_reg   <= hwdata[MPOC_POS_IMMEDIATE];
				override_sync_select_reg    <= hwdata[MPOC_POS_OVR_SYNC];
				buffer_transfer_inhibit_reg <= hwdata[MPOC_POS_INHIBIT];
			end
			if (wr_hit(MPOC_OFS_DT_VALUES, dp_addr_reg, wr_strobe)) begin
				deadtime_b_prescale_reg <= hwdata[MPOC_POS_DTB_PS +: 2];    // see (RULE_10)
				deadtime_b_count_reg    <= hwdata[MPOC_POS_DTB_COUNT +: 6]; // see (RULE_12)
				deadtime_a_prescale_reg <= hwdata[MPOC_POS_DTA_PS +: 2];    // see (RULE_11)
				deadtime_a_count_reg    <= hwdata[MPOC_POS_DTA_COUNT +: 6]; // see (RULE_13)
			end
			if (wr_hit(MPOC_OFS_DT_SELECT, dp_addr_reg, wr_strobe))
				edge_source_reg <= hwdata[5:0] & PIN_MASK;
			if (wr_hit(MPOC_OFS_FAULT, dp_addr_reg, wr_strobe)) begin
				fault_override_level_reg <= hwdata[MPOC_POS_FAULT_OVR +: 6] & PIN_MASK;
				fault_cycle_mode_reg     <= hwdata[MPOC_POS_FAULT_MODE];
				fault_enable_reg         <= hwdata[MPOC_POS_FAULT_EN +: 3] & PAIR_MASK;
			end
		end
	end

	// Fault A input: synchronised, active low at the pin
	logic fault_sync1_reg;
	logic fault_sync2_reg;
	logic fault_held_reg;
	logic fault_active;
	logic fault_release;
	logic fault_sw_clear;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_sync1_reg <= 1'b0;
			fault_sync2_reg <= 1'b0;
		end else if (clk_en) begin
			fault_sync1_reg <= !fault_a_pin_n;
			fault_sync2_reg <= fault_sync1_reg;
		end
	end

	assign fault_active   = fault_sync2_reg;
	assign fault_sw_clear = wr_hit(MPOC_OFS_STATUS, dp_addr_reg, wr_strobe)
	                        && hwdata[MPOC_POS_ST_FAULT_HELD];
	assign fault_release  = fault_cycle_mode_reg ? time_base_sync // see (RULE_17)
	                                             : fault_sw_clear; // see (RULE_18)

	// A fault present in the clearing cycle keeps the hold set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			fault_held_reg <= 1'b0;
		else if (clk_en) begin
			if (fault_active)
				fault_held_reg <= 1'b1;
			else if (fault_release)
				fault_held_reg <= 1'b0;
		end
	end

	// Duty and period buffer transfers
	logic duty_pend_reg;
	logic duty_go;

	assign duty_go = !buffer_transfer_inhibit_reg // see (RULE_09)
	                 && (immediate_duty_update_reg ? duty_buffer_write // see (RULE_07)
	                                               : (time_base_sync && duty_pend_reg));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			duty_pend_reg   <= 1'b0;
			duty_transfer   <= 1'b0;
			period_transfer <= 1'b0;
		end else if (clk_en) begin
			if (duty_buffer_write && !(immediate_duty_update_reg && duty_go))
				duty_pend_reg <= 1'b1;
			else if (duty_go)
				duty_pend_reg <= 1'b0;
			duty_transfer   <= duty_go;
			period_transfer <= time_base_sync && !buffer_transfer_inhibit_reg; // see (RULE_09)
		end
	end

	// Manual override: loaded at once or at the time-base sync point
	logic [5:0] ovr_ctl_reg;
	logic [5:0] ovr_val_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovr_ctl_reg <= MPOC_RST_OVR_CTL;
			ovr_val_reg <= MPOC_RST_OVR_VAL;
		end else if (clk_en && (!override_sync_select_reg || time_base_sync)) begin // see (RULE_08)
			ovr_ctl_reg <= override_pwm_control;
			ovr_val_reg <= override_manual_value;
		end
	end

	// Special event postscaler
	logic [3:0] post_cnt_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			post_cnt_reg          <= 4'h0;
			special_event_trigger <= 1'b0;
		end else if (clk_en) begin
			special_event_trigger <= 1'b0;
			if (special_event_match) begin
				if (post_cnt_reg >= trigger_postscale_reg) begin // see (RULE_06)
					post_cnt_reg          <= 4'h0;
					special_event_trigger <= 1'b1;
				end else begin
					post_cnt_reg <= post_cnt_reg + 4'h1;
				end
			end
		end
	end

	// Dead-time lengths of both units
	logic [MPOC_DT_LEN_W-1:0] len_a;
	logic [MPOC_DT_LEN_W-1:0] len_b;
	logic [2:0]               dt_high;
	logic [2:0]               dt_low;

	assign len_a = mpoc_dt_len(deadtime_a_count_reg, deadtime_a_prescale_reg); // see (RULE_11)
	assign len_b = mpoc_dt_len(deadtime_b_count_reg, deadtime_b_prescale_reg); // see (RULE_10)

	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_pair
			if (p < PAIR_COUNT) begin : g_on
				mpoc_deadtime u_dt (
					.hclk     (hclk),
					.hresetn  (hresetn),
					.clk_en   (clk_en),
					.raw_in   (pwm_raw_high[p]),
					.rise_len (edge_source_reg[2*p+1] ? len_b : len_a), // see (RULE_14)
					.fall_len (edge_source_reg[2*p] ? len_b : len_a),   // see (RULE_15)
					.high_out (dt_high[p]),
					.low_out  (dt_low[p])
				);
			end else begin : g_off
				assign dt_high[p] = 1'b0;
				assign dt_low[p]  = 1'b0;
			end
		end
	endgenerate

	// Pin levels: fault over manual override over generator
	logic [5:0] gen_pin;
	logic [5:0] pin_next;
	logic       force_fault;

	assign force_fault = fault_active || fault_held_reg;

	always_comb begin
		gen_pin  = 6'h00;
		pin_next = 6'h00;
		for (int i = 0; i < 3; i++) begin
			if (pair_independent_select_reg[i]) begin // see (RULE_01)
				gen_pin[2*i+1] = pwm_raw_high[i];
				gen_pin[2*i]   = pwm_raw_low[i];
			end else begin
				gen_pin[2*i+1] = dt_high[i];
				gen_pin[2*i]   = dt_low[i]; // see (RULE_02)
			end
		end
		for (int j = 0; j < 6; j++) begin
			pin_next[j] = ovr_ctl_reg[j] ? gen_pin[j] : ovr_val_reg[j];
			if (force_fault && fault_enable_reg[j/2]) // see (RULE_19)
				pin_next[j] = fault_override_level_reg[j]; // see (RULE_16)
		end
		pin_next = pin_next & PIN_MASK;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			high_side_output <= 3'h0;
			low_side_output  <= 3'h0;
		end else if (clk_en) begin
			high_side_output <= {pin_next[5], pin_next[3], pin_next[1]} & high_pin_enable_reg; // see (RULE_03)
			low_side_output  <= {pin_next[4], pin_next[2], pin_next[0]} & low_pin_enable_reg; // see (RULE_04)
		end
	end

	assign high_side_drive_en = high_pin_enable_reg; // see (RULE_03)
	assign low_side_drive_en  = low_pin_enable_reg;  // see (RULE_04)

	// Read-back; unused bits and unmapped offsets are zero
	logic [15:0] rd_word;

	always_comb begin
		rd_word = 16'h0000;
		case (dp_addr_reg)
			MPOC_OFS_PAIR_PIN: begin
				rd_word[MPOC_POS_PAIR_MODE +: 3] = pair_independent_select_reg;
				rd_word[MPOC_POS_HIGH_EN +: 3]   = high_pin_enable_reg;
				rd_word[MPOC_POS_LOW_EN +: 3]    = low_pin_enable_reg;
			end
			MPOC_OFS_UPDATE: begin
				rd_word[MPOC_POS_POSTSCALE +: 4] = trigger_postscale_reg;
				rd_word[MPOC_POS_IMMEDIATE]      = immediate_duty_update_reg;
				rd_word[MPOC_POS_OVR_SYNC]       = override_sync_select_reg;
				rd_word[MPOC_POS_INHIBIT]        = buffer_transfer_inhibit_reg;
			end
			MPOC_OFS_DT_VALUES: begin
				rd_word[MPOC_POS_DTB_PS +: 2]    = deadtime_b_prescale_reg;
				rd_word[MPOC_POS_DTB_COUNT +: 6] = deadtime_b_count_reg;
				rd_word[MPOC_POS_DTA_PS +: 2]    = deadtime_a_prescale_reg;
				rd_word[MPOC_POS_DTA_COUNT +: 6] = deadtime_a_count_reg;
			end
			MPOC_OFS_DT_SELECT: rd_word[5:0] = edge_source_reg;
			MPOC_OFS_FAULT: begin
				rd_word[MPOC_POS_FAULT_OVR +: 6] = fault_override_level_reg;
				rd_word[MPOC_POS_FAULT_MODE]     = fault_cycle_mode_reg;
				rd_word[MPOC_POS_FAULT_EN +: 3]  = fault_enable_reg;
			end
			MPOC_OFS_STATUS: begin
				rd_word[MPOC_POS_ST_FAULT_IN]   = fault_active;
				rd_word[MPOC_POS_ST_FAULT_HELD] = fault_held_reg;
				rd_word[MPOC_POS_ST_DUTY_PEND]  = duty_pend_reg;
				rd_word[MPOC_POS_ST_STRAP]      = strap_sync2_reg;
			end
			default: rd_word = 16'h0000;
		endcase
	end

	assign hrdata = rd_pend_reg ? {16'h0000, rd_word} : 32'h0000_0000; // see (RULE_21)

endmodule // mpoc_top

// [testbench/mpoc_sva.sv]
/*
 * Port assertions for the motor PWM output control block.
 * Assumes a single hclk domain and is bound to every mpoc_top instance.
 */
`timescale 1ns/100ps
module mpoc_sva #(
	parameter int PAIR_COUNT = 3
)(
	input logic        hclk,
	input logic        hresetn,
	input logic        clk_en,
	input logic        hreadyout,
	input logic        hresp,
	input logic [31:0] hrdata,
	input logic [2:0]  high_side_output,
	input logic [2:0]  low_side_output,
	input logic [2:0]  high_side_drive_en,
	input logic [2:0]  low_side_drive_en,
	input logic        special_event_trigger,
	input logic        special_event_match,
	input logic        time_base_sync,
	input logic        duty_buffer_write,
	input logic        duty_transfer,
	input logic        period_transfer
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_en: assert property (hreadyout == clk_en)
		else $error("ready does not follow clock enable");
	a_resp_okay: assert property (!hresp)
		else $error("error response seen");
	a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_high_gpio: assert property ((high_side_output & ~high_side_drive_en) == 3'h0)
		else $error("released high pin driven");
	a_low_gpio: assert property ((low_side_output & ~low_side_drive_en) == 3'h0)
		else $error("released low pin driven");
	a_pair_limit: assert property (((high_side_output | low_side_output | high_side_drive_en
		| low_side_drive_en) >> PAIR_COUNT) == 3'h0) else $error("absent pair active");
	a_trig_cause: assert property (special_event_trigger |-> $past(special_event_match))
		else $error("trigger without match");
	a_period_sync: assert property (period_transfer |-> $past(time_base_sync))
		else $error("period transfer without sync");
	a_duty_cause: assert property (duty_transfer |-> $past(duty_buffer_write | time_base_sync))
		else $error("duty transfer without cause");
endmodule // mpoc_sva

bind mpoc_top mpoc_sva #(.PAIR_COUNT(PAIR_COUNT)) sva_u (.hclk, .hresetn, .clk_en, .hreadyout,
	.hresp, .hrdata, .high_side_output, .low_side_output, .high_side_drive_en, .low_side_drive_en,
	.special_event_trigger, .special_event_match, .time_base_sync, .duty_buffer_write,
	.duty_transfer, .period_transfer);

// [testbench/mpoc_power_stage.sv]
/*
 * Power stage and fault sensing model.
 * Assumes the bench requests faults; counts cycles with both switches of a leg on.
 */
`timescale 1ns/100ps
module mpoc_power_stage (
	input  logic       hclk,
	input  logic       fault_req,
	input  logic [2:0] high_side_output,
	input  logic [2:0] low_side_output,
	output logic       fault_a_pin_n,
	output int         overlap
);
	initial begin
		fault_a_pin_n = 1'b1;
		overlap = 0;
	end
	always @(posedge hclk) begin
		fault_a_pin_n <= !fault_req;
		if (|(high_side_output & low_side_output))
			overlap <= overlap + 1;
	end
endmodule // mpoc_power_stage

// [testbench/motor_pwm_output_control_bench.sv]
/*
 * Self-checking bench for the motor PWM output control block.
 * Assumes one AHB-Lite slave at hclk 40 MHz and the power stage model on the pins.
 */
`timescale 1ns/100ps
module motor_pwm_output_control_bench;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fault_req = 0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0, pwm_raw_high = 3'h0, ev = 3'h0;
	logic [5:0] ovc = 6'h3F;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd, rd_s;
	wire hreadyout, hresp, special_event_trigger, duty_transfer, period_transfer, fault_a_pin_n;
	wire [31:0] hrdata;
	wire [2:0] hso, lso, hde, lde;
	int errors = 0, n_checks = 0, overlap, trig_n = 0, dt_n = 0, pt_n = 0;

	mpoc_top dut_u (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pin_owner_config_bit(1'b1),
		.fault_a_pin_n, .pwm_raw_high, .pwm_raw_low(3'h0), .time_base_sync(ev[2]),
		.special_event_match(ev[1]), .duty_buffer_write(ev[0]), .override_pwm_control(ovc),
		.override_manual_value(6'h00), .high_side_output(hso), .low_side_output(lso),
		.high_side_drive_en(hde), .low_side_drive_en(lde), .special_event_trigger,
		.duty_transfer, .period_transfer);
	mpoc_power_stage pst_u (.hclk, .fault_req, .high_side_output(hso), .low_side_output(lso),
		.fault_a_pin_n, .overlap);

	always #12.5 hclk = ~hclk;
	always @(posedge hclk) begin
		if (special_event_trigger === 1'b1) trig_n++;
		if (duty_transfer === 1'b1) dt_n++;
		if (period_transfer === 1'b1) pt_n++;
	end

	task results;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Waits for hready high at a rising edge; read data is captured just before that edge
	task rdy;
		int k;
		k = 0;
		do begin @(negedge hclk); k++; rd_s = hrdata; end while (hreadyout !== 1'b1 && k < 50);
		@(posedge hclk);
		if (k >= 50) begin errors++; results; end
	endtask
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1; haddr <= {24'h00_0000, a}; hwrite <= w; hsize <= 3'h2; htrans <= 2'h2;
		rdy;
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		rdy;
		rd = rd_s;
	endtask
	task pul(input logic [2:0] v);
		@(posedge hclk); ev <= v;
		@(posedge hclk); ev <= 3'h0;
		repeat (4) @(posedge hclk);
	endtask

	task t_regs;
		logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
		logic [15:0] m[6] = '{16'h0777, 16'h0F07, 16'hFFFF, 16'h003F, 16'h3F87, 16'h0000};
		for (int i = 0; i < 6; i++) begin
			bus(a[i], 0, 0); chk("reset value", rd, (i == 0) ? 32'h0000_0077 : 32'h0000_0000);
			bus(a[i], 1, 32'hFFFF_FFFF); bus(a[i], 0, 0); chk("write mask", rd, {16'h0000, m[i]});
			bus(a[i], 1, (i == 0) ? 32'h0000_0077 : 32'h0000_0000);
		end
	endtask
	task t_events;
		bus(8'h04, 1, 32'h0000_0200);
		repeat (6) pul(3'b010);
		chk("trigger count", trig_n, 2);
		bus(8'h04, 1, 32'h0000_0000); pul(3'b001);
		chk("duty held", dt_n, 0);
		pul(3'b100); chk("duty at sync", dt_n, 1);
		bus(8'h04, 1, 32'h0000_0001); pul(3'b100); chk("period inhibited", pt_n, 1);
		bus(8'h04, 1, 32'h0000_0004); pul(3'b001); chk("duty immediate", dt_n, 2);
	endtask
	task t_dt(input logic [31:0] dv, input logic [31:0] sv, input int g);
		int n, k;
		bus(8'h08, 1, dv); bus(8'h0C, 1, sv);
		for (int e = 1; e >= 0; e--) begin
			@(posedge hclk); pwm_raw_high <= {2'h0, e[0]}; n = 0; k = 0;
			do begin @(negedge hclk); k++; n += (hso[0] === 1'b0 && lso[0] === 1'b0); end
			while ((e ? hso[0] : lso[0]) !== 1'b1 && k < 200);
			if (k >= 200) begin errors++; results; end
			chk("dead time", n, g);
		end
		chk("overlap", overlap, 0);
	endtask
	task t_fault;
		bus(8'h10, 1, 32'h0000_0201); fault_req <= 1'b1; repeat (6) @(posedge hclk);
		chk("fault levels", {hso[1:0], lso[1:0]}, 4'b0110);
		fault_req <= 1'b0; repeat (6) @(posedge hclk);
		chk("fault latched", {hso[0], lso[0]}, 2'b10);
		bus(8'h14, 1, 32'h0000_0002); repeat (4) @(posedge hclk);
		chk("fault cleared", {hso[0], lso[0]}, 2'b01);
		bus(8'h10, 1, 32'h0000_0281); fault_req <= 1'b1; repeat (6) @(posedge hclk);
		fault_req <= 1'b0; repeat (4) @(posedge hclk); pul(3'b100);
		chk("cycle release", {hso[0], lso[0]}, 2'b01);
	endtask
	task t_ovr;
		bus(8'h04, 1, 32'h0000_0002); ovc <= 6'h3E; repeat (4) @(posedge hclk);
		chk("override held", lso[0], 1'b1);
		pul(3'b100); chk("override synced", lso[0], 1'b0);
		bus(8'h04, 1, 32'h0000_0000); ovc <= 6'h3F; repeat (3) @(posedge hclk);
		chk("override released", lso[0], 1'b1);
	endtask

	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		t_regs;
		t_events;
		t_dt(32'h0000_0043, 32'h0000_0000, 6);
		t_dt(32'h0000_C200, 32'h0000_0003, 16);
		t_fault;
		t_ovr;
		results;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		errors++;
		results;
	end
endmodule // motor_pwm_output_control_bench
